// ---- hw/vic_top.sv ----
/*
  vic_top: vectored interrupt controller with AXI4-Lite registers.
  assumes a cpu core that takes irq_req/irq_vector and pulses irq_ack for
  one cycle when it latches the vector; peripheral requests are levels
  already gated by the peripherals' own enables; pins are asynchronous.
*/
// Behaviour
// [R1] nonmaskable request always taken, highest priority
// [R2] global mask holds back all other requests
// [R3] control bit 2 picks nonmaskable edge
// [R4] sense bit picks low level or falling edge
// [R5] enable bit n gates new requests line n
// [R6] edge request latched pending until served
// [R7] disabling keeps an already pending request
// [R8] mask, sense 0, enable 0 clears pending
// [R9] software discards pending via mask, enable, sense
// [R10] vectoring sets the global mask bit
// [R11] lowest vector number wins arbitration
// [R12] vector entry at byte address twice vector
// [R13] masked key inputs ORed into line six
// [R14] low and high masks cover keys 0-15
// [R15] mask 0 passes key, 1 blocks it
// [R16] reset masks all keys except key six
// [R17] 26 internal requests, vectors 12 to 37
// [R18] watchdog goes to nonmaskable or vector 36
// [R19] cpu finishes instruction, then latches vector
// [R20] peripheral request counts only while enabled
// [R21] level request only while input stays low
`include "vic_cfg.svh"
`timescale 1ns/1ps
module vic_top #(
  parameter int NINT = 26
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register bus
  input wire vic_pkg::vic_axi_req_t axi_req,
  output vic_pkg::vic_axi_rsp_t axi_rsp,
  // pins, active low
  input wire logic nmi_pin,
  input wire logic [7:0] line_n,
  input wire logic [15:0] key_sense_input_n,
  // on-chip requests, bit 24 is the watchdog overflow
  input wire logic [NINT-1:0] int_req,
  // cpu core
  output logic irq_req,
  output logic [5:0] irq_vector,
  output logic [15:0] irq_vector_addr,
  output logic global_mask,
  input wire logic irq_ack
);
  vic_pkg::vic_state_t st_r;
  vic_pkg::vic_state_t st_nxt;
  logic [7:0] low;
  logic [7:0] fall;
  logic [7:0] ext_req;
  logic [7:0] clr;
  logic [NINT-1:0] int_live;
  logic [`VIC_NSRC-1:0] acc;
  logic nmi_edge;
  logic wdt_rise;
  logic [5:0] win_vec;
  logic win;
  logic wr_go;
  logic [15:0] wr_idx;
  logic [15:0] rd_idx;
  logic [15:0] keys_on;

  // key inputs gated by their masks, 0 passes [R14] [R15]
  assign keys_on = ~st_r.k2 & ~{st_r.kmhi, st_r.kmlo};

  // synchronised line levels, line six shares the key sense [R13]
  always_comb begin
    low = ~st_r.s2[7:0];
    low[`VIC_KEY_LINE] = low[`VIC_KEY_LINE] | (|keys_on); // [R13]
  end

  // falling edges as new active-low levels
  assign fall = low & ~st_r.d[7:0];

  // nonmaskable edge, polarity from control bit [R3]
  assign nmi_edge = st_r.sysctl[`VIC_SYS_NMI_EDGE] ?
                    (st_r.s2[8] & ~st_r.d[8]) : (~st_r.s2[8] & st_r.d[8]);

  // watchdog overflow rising edge for the nonmaskable route [R18]
  assign wdt_rise = st_r.wdt_nmi & int_req[`VIC_WDT_INT] & ~st_r.wdt_d;

  // per-line request and discard condition
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_line
      // pending edge or live low level while enabled [R21] [R5]
      assign ext_req[g] = st_r.pend[g] |
                          (~st_r.sense[g] & low[g] & st_r.en[g]);
      assign clr[g] = st_r.gmask & ~st_r.sense[g] & ~st_r.en[g]; // [R8]
    end
  endgenerate

  // peripheral levels, watchdog held back when routed away [R17] [R18]
  always_comb begin
    int_live = int_req; // [R20]
    int_live[`VIC_WDT_INT] = int_req[`VIC_WDT_INT] & ~st_r.wdt_nmi;
  end

  // accepted set, nonmaskable ignores the mask [R1] [R2]
  assign acc = {int_live & {NINT{~st_r.gmask}},
                ext_req & {8{~st_r.gmask}},
                st_r.nmi_pend};

  // fixed priority, lowest source index wins [R11]
  always_comb begin
    win = 1'b0;
    win_vec = `VIC_VEC_NMI;
    for (int i = `VIC_NSRC - 1; i >= 0; i--) begin
      if (acc[i]) begin
        win = 1'b1;
        win_vec = 6'(i) + `VIC_VEC_NMI; // [R11]
      end
    end
  end

  // register write decode
  assign wr_go = st_r.aw_v & st_r.w_v & ~st_r.bvalid;
  assign wr_idx = st_r.aw_addr[17:2];
  assign rd_idx = axi_req.araddr[17:2];

  // next state
  always_comb begin
    st_nxt = st_r;
    // pin synchronisers, first stage only feeds second
    st_nxt.s1 = {nmi_pin, line_n};
    st_nxt.s2 = st_r.s1;
    st_nxt.k1 = key_sense_input_n;
    st_nxt.k2 = st_r.k1;
    st_nxt.d = {st_r.s2[8], low};
    st_nxt.wdt_d = int_req[`VIC_WDT_INT];

    // pending edge requests, set wins over clear [R6] [R7] [R8]
    for (int n = 0; n < 8; n++) begin
      if ((clr[n]) ||
          (irq_ack && st_r.vec == `VIC_VEC_EXT0 + 6'(n))) begin
        st_nxt.pend[n] = 1'b0; // [R8]
      end
      if (st_r.sense[n] && st_r.en[n] && fall[n]) begin
        st_nxt.pend[n] = 1'b1; // [R4] [R5] [R6]
      end
    end

    // nonmaskable pending, cleared when served [R1]
    if (irq_ack && st_r.vec == `VIC_VEC_NMI) begin
      st_nxt.nmi_pend = 1'b0;
    end
    if (nmi_edge || wdt_rise) begin
      st_nxt.nmi_pend = 1'b1; // [R1] [R18]
    end

    // request and vector to the core, registered [R19]
    st_nxt.req = win;
    st_nxt.vec = win_vec;

    // write address and data taken in either order
    if (axi_req.awvalid && !st_r.aw_v && !st_r.bvalid) begin
      st_nxt.aw_v = 1'b1;
      st_nxt.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !st_r.w_v && !st_r.bvalid) begin
      st_nxt.w_v = 1'b1;
      st_nxt.w_byte = axi_req.wdata[7:0];
      st_nxt.w_lane = axi_req.wstrb[0];
    end
    if (st_r.bvalid && axi_req.bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (wr_go) begin
      st_nxt.aw_v = 1'b0;
      st_nxt.w_v = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = `VIC_RESP_OKAY;
      unique case (wr_idx)
        `VIC_IDX_SYSCTL: if (st_r.w_lane) begin
          st_nxt.sysctl = st_r.w_byte;
          st_nxt.sysctl[`VIC_SYS_RESET_SRC] =
            st_r.sysctl[`VIC_SYS_RESET_SRC];
        end
        `VIC_IDX_SENSE: if (st_r.w_lane) begin
          st_nxt.sense = st_r.w_byte; // [R4] [R9]
        end
        `VIC_IDX_ENABLE: if (st_r.w_lane) begin
          st_nxt.en = st_r.w_byte; // [R5]
        end
        `VIC_IDX_KMLO: if (st_r.w_lane) begin
          st_nxt.kmlo = st_r.w_byte; // [R14]
        end
        `VIC_IDX_KMHI: if (st_r.w_lane) begin
          st_nxt.kmhi = st_r.w_byte; // [R14]
        end
        `VIC_IDX_CTRL: if (st_r.w_lane) begin
          st_nxt.gmask = st_r.w_byte[`VIC_CTRL_GMASK];
          st_nxt.wdt_nmi = st_r.w_byte[`VIC_CTRL_WDT_NMI];
        end
        `VIC_IDX_STAT: ;
        default: st_nxt.bresp = `VIC_RESP_SLVERR;
      endcase
    end

    // vectoring sets the mask, winning over a software clear [R10]
    if (irq_ack) begin
      st_nxt.gmask = 1'b1;
    end

    // read channel, one read outstanding
    if (st_r.rvalid && axi_req.rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = `VIC_RESP_OKAY;
      st_nxt.rdata = 32'h0000_0000;
      unique case (rd_idx)
        `VIC_IDX_SYSCTL: st_nxt.rdata[7:0] = st_r.sysctl;
        `VIC_IDX_SENSE: st_nxt.rdata[7:0] = st_r.sense;
        `VIC_IDX_ENABLE: st_nxt.rdata[7:0] = st_r.en;
        `VIC_IDX_KMLO: st_nxt.rdata[7:0] = st_r.kmlo;
        `VIC_IDX_KMHI: st_nxt.rdata[7:0] = st_r.kmhi;
        `VIC_IDX_CTRL: begin
          st_nxt.rdata[`VIC_CTRL_GMASK] = st_r.gmask;
          st_nxt.rdata[`VIC_CTRL_WDT_NMI] = st_r.wdt_nmi;
        end
        `VIC_IDX_STAT: begin
          st_nxt.rdata[7:0] = st_r.pend;
          st_nxt.rdata[`VIC_STAT_NMI] = st_r.nmi_pend;
          st_nxt.rdata[`VIC_STAT_VEC +: 6] = st_r.vec;
          st_nxt.rdata[`VIC_STAT_REQ] = st_r.req;
        end
        default: st_nxt.rresp = `VIC_RESP_SLVERR;
      endcase
    end
  end

  // state register with synchronous reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
      st_r.sysctl <= `VIC_RST_SYSCTL; // [R3]
      st_r.sense <= `VIC_RST_SENSE;
      st_r.en <= `VIC_RST_ENABLE;
      st_r.kmlo <= `VIC_RST_KMLO; // [R16]
      st_r.kmhi <= `VIC_RST_KMHI; // [R16]
      st_r.gmask <= 1'b1;
      st_r.s1 <= '1;
      st_r.s2 <= '1;
      st_r.d <= 9'h100;
      st_r.k1 <= '1;
      st_r.k2 <= '1;
      st_r.vec <= `VIC_VEC_NMI;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs
  assign irq_req = st_r.req;
  assign irq_vector = st_r.vec;
  assign irq_vector_addr = {9'h000, st_r.vec, 1'b0}; // [R12]
  assign global_mask = st_r.gmask;
  assign axi_rsp.awready = ~st_r.aw_v & ~st_r.bvalid;
  assign axi_rsp.wready = ~st_r.w_v & ~st_r.bvalid;
  assign axi_rsp.bvalid = st_r.bvalid;
  assign axi_rsp.bresp = st_r.bresp;
  assign axi_rsp.arready = ~st_r.rvalid;
  assign axi_rsp.rvalid = st_r.rvalid;
  assign axi_rsp.rdata = st_r.rdata;
  assign axi_rsp.rresp = st_r.rresp;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence nmi_fall_s;
    !st_r.sysctl[`VIC_SYS_NMI_EDGE] && st_r.d[8] && !st_r.s2[8];
  endsequence

  sequence nmi_served_s;
    irq_req && irq_vector == `VIC_VEC_NMI;
  endsequence

  sequence line0_fall_s;
    st_r.sense[0] && st_r.en[0] && fall[0];
  endsequence

  nmi_edge_a: assert property (nmi_fall_s |=> st_r.nmi_pend) // [R3]
    else $error("nonmaskable falling edge not latched");

  nmi_first_a: assert property ( // [R1]
    (st_r.nmi_pend && !irq_ack) |=> nmi_served_s)
    else $error("pending nonmaskable not presented first");

  mask_block_a: assert property ( // [R2]
    (st_r.gmask && !st_r.nmi_pend) |=> !irq_req)
    else $error("masked request reached the core");

  edge_latch_a: assert property ( // [R6]
    line0_fall_s ##1 (!irq_ack && !clr[0])[*2] |=> st_r.pend[0])
    else $error("edge request on line 0 not held");

  enable_gate_a: assert property ( // [R5]
    (!st_r.en[0] && !st_r.pend[0]) |=> !st_r.pend[0])
    else $error("disabled line 0 latched a request");

  keep_pend_a: assert property ( // [R7]
    (st_r.pend[0] && !clr[0] && !(irq_ack && irq_vector == `VIC_VEC_EXT0))
    |=> st_r.pend[0])
    else $error("pending request on line 0 lost");

  discard_a: assert property ( // [R8]
    clr[1] |=> !st_r.pend[1])
    else $error("pending request on line 1 not discarded");

  ack_mask_a: assert property (irq_ack |=> global_mask) // [R10]
    else $error("vectoring left the global mask clear");

  prio_a: assert property ( // [R11]
    (!st_r.gmask && ext_req[0] && !st_r.nmi_pend && !irq_ack)
    |=> irq_vector == `VIC_VEC_EXT0)
    else $error("line 0 lost arbitration to a lower priority");

  vec_addr_a: assert property ( // [R12]
    irq_req |-> (irq_vector_addr[0] == 1'b0 &&
                 irq_vector_addr >= 16'h0006 &&
                 irq_vector_addr <= 16'h004a))
    else $error("vector address outside the vector table");

  key_block_a: assert property ( // [R15]
    ({st_r.kmhi, st_r.kmlo} == 16'hffff && st_r.s2[6]) |-> !low[6])
    else $error("masked key reached line 6");

  level_a: assert property ( // [R21]
    (!st_r.sense[7] && !st_r.pend[7]) |=> !st_r.pend[7])
    else $error("level request on line 7 was latched");

  wdt_route_a: assert property ( // [R18]
    (st_r.wdt_nmi && int_req[`VIC_WDT_INT] && !st_r.wdt_d)
    |=> st_r.nmi_pend)
    else $error("watchdog overflow did not raise nonmaskable");

  // rising nonmaskable edge, key 9, vector 12, bus answers and later steps of vectoring
  sequence wr_both_s;
    axi_req.awvalid && axi_req.wvalid && axi_rsp.awready && axi_rsp.wready;
  endsequence

  nmi_rise_a: assert property ( // [R3]
    (st_r.sysctl[`VIC_SYS_NMI_EDGE] && !st_r.d[8] && st_r.s2[8])
    |=> st_r.nmi_pend)
    else $error("nonmaskable rising edge not latched");

  key_pass_a: assert property ( // [R13]
    (!st_r.kmhi[1] && !st_r.k2[9]) |-> low[`VIC_KEY_LINE])
    else $error("unmasked key 9 did not reach line 6");

  int_prio_a: assert property ( // [R17]
    (!st_r.gmask && !st_r.nmi_pend && ext_req == 8'h00 && int_req[0])
    |=> irq_vector == `VIC_VEC_EXT7 + 6'h01)
    else $error("capture request not given vector 12");

  ack_drop_a: assert property ( // [R2]
    irq_ack |=> ##1 (!irq_req || irq_vector == `VIC_VEC_NMI))
    else $error("masked request presented after vectoring");

  wr_answer_a: assert property (wr_both_s |=> ##1 axi_rsp.bvalid)
    else $error("write response missing");

  rd_answer_a: assert property (
    (axi_req.arvalid && axi_rsp.arready) |=> axi_rsp.rvalid)
    else $error("read data missing");
endmodule : vic_top

// ---- pkg/vic_cfg.svh ----
/*
  vic_cfg.svh: offsets, field positions, reset values and vector numbers
  of the vectored interrupt controller. assumes inclusion by bare name.
*/
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
// register indices, byte address is four times the index
`define VIC_IDX_SYSCTL 16'hffc4
`define VIC_IDX_SENSE 16'hffc6
`define VIC_IDX_ENABLE 16'hffc7
`define VIC_IDX_KMLO 16'hfff1
`define VIC_IDX_KMHI 16'hfff3
`define VIC_IDX_CTRL 16'hffc8
`define VIC_IDX_STAT 16'hffc9
// reset values
`define VIC_RST_SYSCTL 8'h09
`define VIC_RST_SENSE 8'h00
`define VIC_RST_ENABLE 8'h00
`define VIC_RST_KMLO 8'hbf
`define VIC_RST_KMHI 8'hff
// field positions
`define VIC_SYS_NMI_EDGE 2
`define VIC_SYS_RESET_SRC 3
`define VIC_CTRL_GMASK 0
`define VIC_CTRL_WDT_NMI 1
`define VIC_STAT_NMI 8
`define VIC_STAT_VEC 16
`define VIC_STAT_REQ 24
// vectors and sources
`define VIC_VEC_NMI 6'h03
`define VIC_VEC_EXT0 6'h04
`define VIC_VEC_EXT7 6'h0b
`define VIC_KEY_LINE 6
`define VIC_WDT_INT 24
`define VIC_NSRC 35
// bus answers
`define VIC_RESP_OKAY 2'h0
`define VIC_RESP_SLVERR 2'h2
`endif

// ---- pkg/vic_pkg.sv ----
/*
  vic_pkg: bus carriers and the state record of the interrupt controller.
  assumes an AXI4-Lite master with 18-bit byte addresses.
*/
package vic_pkg;
  typedef struct packed {
    logic awvalid;
    logic [17:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [17:0] araddr;
    logic rready;
  } vic_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vic_axi_rsp_t;

  typedef struct packed {
    logic [7:0] sysctl;
    logic [7:0] sense;
    logic [7:0] en;
    logic [7:0] kmlo;
    logic [7:0] kmhi;
    logic gmask;
    logic wdt_nmi;
    logic [7:0] pend;
    logic nmi_pend;
    logic [8:0] s1;
    logic [8:0] s2;
    logic [8:0] d;
    logic [15:0] k1;
    logic [15:0] k2;
    logic wdt_d;
    logic req;
    logic [5:0] vec;
    logic aw_v;
    logic [17:0] aw_addr;
    logic w_v;
    logic [7:0] w_byte;
    logic w_lane;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vic_state_t;
endpackage : vic_pkg

// ---- testbench/tb_vic_top.sv ----
/*
  tb_vic_top: register and request sequences for vic_top.
  assumes vic_cpu_model as core and an AXI4-Lite master in tasks.
*/
`include "vic_cfg.svh"
`timescale 1ns/1ps
module tb_vic_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  vic_pkg::vic_axi_req_t q = '0;
  vic_pkg::vic_axi_rsp_t s;
  logic nmi_pin = 1'b1;
  logic [7:0] line_n = 8'hff;
  logic [15:0] key_n = 16'hffff;
  logic [25:0] int_req = 26'h0;
  logic [3:0] lat = 4'h0;
  logic irq_req, global_mask, irq_ack;
  logic [5:0] irq_vector, last_vec;
  logic [15:0] irq_vector_addr, last_addr;
  logic [7:0] n_taken;
  logic [1:0] ok = `VIC_RESP_OKAY;
  logic [1:0] se = `VIC_RESP_SLVERR;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;

  // 100 MHz clock
  always #5 mclk = ~mclk;

  vic_top vic_top_i (.mclk(mclk), .rst(rst), .axi_req(q), .axi_rsp(s),
    .nmi_pin(nmi_pin), .line_n(line_n), .key_sense_input_n(key_n),
    .int_req(int_req), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_vector_addr(irq_vector_addr), .global_mask(global_mask),
    .irq_ack(irq_ack));

  vic_cpu_model vic_cpu_model_i (.mclk(mclk), .rst(rst), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_vector_addr(irq_vector_addr),
    .irq_ack(irq_ack), .lat(lat), .last_vec(last_vec),
    .last_addr(last_addr), .n_taken(n_taken));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // write address and data offered together, bready held until bvalid
  task automatic wr(input logic [15:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    q.awvalid <= 1'b1;
    q.awaddr <= {idx, 2'b00};
    q.wvalid <= 1'b1;
    q.wdata <= {24'h000000, d};
    q.wstrb <= 4'hf;
    q.bready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s.awready) q.awvalid <= 1'b0;
      if (s.wready) q.wvalid <= 1'b0;
      if (s.bvalid) begin
        q.bready <= 1'b0;
        done = 1'b1;
        chk(s.bresp, er);
      end
    end
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [7:0] d,
                    input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    q.arvalid <= 1'b1;
    q.araddr <= {idx, 2'b00};
    q.rready <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (s.arready) q.arvalid <= 1'b0;
      if (s.rvalid) begin
        q.rready <= 1'b0;
        done = 1'b1;
        chk(s.rdata, {24'h000000, d});
        chk(s.rresp, er);
      end
    end
  endtask : rd

  // optionally drop the mask, then wait for the core to take a vector
  task automatic serve(input logic [5:0] v, input logic clr);
    int w;
    logic [7:0] k;
    if (clr) wr(`VIC_IDX_CTRL, 8'h00, ok);
    k = n_taken;
    w = 0;
    while (n_taken == k && w < 80) begin
      @(posedge mclk);
      w++;
    end
    repeat (2) @(posedge mclk);
    #1;
    chk(last_vec, v);
    chk(last_addr, {v, 1'b0});
    chk(global_mask, 32'h1);
  endtask : serve

  // no request may reach the core
  task automatic quiet();
    logic [7:0] k;
    k = n_taken;
    repeat (10) @(posedge mclk);
    #1;
    chk(irq_req, 32'h0);
    chk(n_taken, k); // nothing vectored meanwhile
  endtask : quiet

  task automatic pulse(input int n);
    @(posedge mclk);
    line_n[n] <= 1'b0;
    repeat (2) @(posedge mclk);
    line_n[n] <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask : pulse

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk(irq_vector_addr, 32'h6);
    rd(`VIC_IDX_SYSCTL, 8'h09, ok);
    rd(`VIC_IDX_SENSE, 8'h00, ok);
    rd(`VIC_IDX_ENABLE, 8'h00, ok);
    rd(`VIC_IDX_KMLO, 8'hbf, ok);
    rd(`VIC_IDX_KMHI, 8'hff, ok);
    rd(16'hffc5, 8'h00, se);
    wr(16'hffc5, 8'hff, se);
    // priority among mixed sources
    wr(`VIC_IDX_ENABLE, 8'h80, ok);
    @(posedge mclk);
    int_req[0] <= 1'b1;
    int_req[25] <= 1'b1;
    line_n[7] <= 1'b0;
    quiet();
    serve(6'h0b, 1'b1);
    line_n[7] <= 1'b1;
    serve(6'h0c, 1'b1);
    int_req[0] <= 1'b0;
    serve(6'h25, 1'b1);
    int_req[25] <= 1'b0;
    // watchdog routing
    int_req[24] <= 1'b1;
    serve(6'h24, 1'b1);
    int_req[24] <= 1'b0;
    wr(`VIC_IDX_CTRL, 8'h03, ok);
    int_req[24] <= 1'b1;
    serve(6'h03, 1'b0);
    int_req[24] <= 1'b0;
    wr(`VIC_IDX_CTRL, 8'h01, ok);
    // nonmaskable edge select
    nmi_pin <= 1'b0;
    serve(6'h03, 1'b0);
    wr(`VIC_IDX_SYSCTL, 8'h05, ok);
    rd(`VIC_IDX_SYSCTL, 8'h0d, ok);
    nmi_pin <= 1'b1;
    serve(6'h03, 1'b0);
    nmi_pin <= 1'b0;
    quiet();
    // edge pending survives disable, slow core
    lat <= 4'h5;
    wr(`VIC_IDX_SENSE, 8'h03, ok);
    wr(`VIC_IDX_ENABLE, 8'h01, ok);
    pulse(0);
    wr(`VIC_IDX_ENABLE, 8'h00, ok);
    serve(6'h04, 1'b1);
    pulse(1);
    wr(`VIC_IDX_CTRL, 8'h00, ok);
    quiet();
    // discard sequence under mask
    wr(`VIC_IDX_CTRL, 8'h01, ok);
    wr(`VIC_IDX_ENABLE, 8'h01, ok);
    pulse(0);
    wr(`VIC_IDX_ENABLE, 8'h00, ok);
    wr(`VIC_IDX_SENSE, 8'h02, ok);
    wr(`VIC_IDX_SENSE, 8'h03, ok);
    wr(`VIC_IDX_CTRL, 8'h00, ok);
    quiet();
    // key inputs onto line six
    wr(`VIC_IDX_SENSE, 8'h00, ok);
    wr(`VIC_IDX_ENABLE, 8'h40, ok);
    wr(`VIC_IDX_KMLO, 8'hff, ok);
    key_n[9] <= 1'b0;
    quiet();
    wr(`VIC_IDX_KMHI, 8'hfd, ok);
    serve(6'h0a, 1'b0);
    key_n[9] <= 1'b1;
    wrap_up();
  end
endmodule : tb_vic_top

// ---- testbench/vic_cpu_model.sv ----
/*
  vic_cpu_model: cpu core stand-in that acks requests after a delay.
  assumes the controller's level request and one-cycle ack handshake.
*/
`timescale 1ns/1ps
module vic_cpu_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // controller side
  input wire logic irq_req,
  input wire logic [5:0] irq_vector,
  input wire logic [15:0] irq_vector_addr,
  output logic irq_ack,
  // bench side
  input wire logic [3:0] lat,
  output logic [5:0] last_vec,
  output logic [15:0] last_addr,
  output logic [7:0] n_taken
);
  logic [3:0] cnt_r;
  logic [1:0] hold_r;
  // finish the current instruction, then latch the vector
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r <= 4'h0;
      hold_r <= 2'h0;
      irq_ack <= 1'b0;
      last_vec <= 6'h00;
      last_addr <= 16'h0000;
      n_taken <= 8'h00;
    end else begin
      irq_ack <= 1'b0;
      if (hold_r != 2'h0) begin
        hold_r <= hold_r - 2'h1; // one ack per presented request
      end else if (irq_req && cnt_r == lat) begin
        irq_ack <= 1'b1;
        last_vec <= irq_vector;
        last_addr <= irq_vector_addr;
        n_taken <= n_taken + 8'h01;
        cnt_r <= 4'h0;
        hold_r <= 2'h3;
      end else if (irq_req) begin
        cnt_r <= cnt_r + 4'h1;
      end else begin
        cnt_r <= 4'h0;
      end
    end
  end
endmodule : vic_cpu_model
